// ===== common/nv_host_pkg.sv
// Purpose: Shared constants and types for the nonvolatile SRAM host controller.
// Assumes: core_clk at 250 MHz; slowest speed grade of the attached part.
// Notes: Times are kept in their printed units; cycle counts derive from them.
`default_nettype none
package nv_host_pkg;

  localparam int unsigned CLK_PERIOD_PS = 4000;

  // Least times round up to whole cycles, never below one
  function automatic int unsigned ceilCycles(input int unsigned timePs);
    int unsigned n;
    n = (timePs + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (n == 0) ? 1 : n;
  endfunction : ceilCycles

  localparam int unsigned ADDR_WIDTH = 13;
  localparam int unsigned DATA_WIDTH = 8;
  localparam int unsigned SEQ_LEN = 6;

  localparam int unsigned READ_ACCESS_NS = 45;
  localparam int unsigned WRITE_PULSE_NS = 30;
  localparam int unsigned SEQ_PULSE_NS = 30;
  localparam int unsigned OUTPUT_OFF_NS = 15;
  localparam int unsigned NV_SAVE_DURATION_MS = 10;
  localparam int unsigned NV_RELOAD_DURATION_US = 20;
  localparam int unsigned POWERUP_RELOAD_DURATION_US = 550;

  localparam int unsigned SYNC_LATENCY = 3;
  localparam int unsigned READ_PULSE_CYCLES = ceilCycles(READ_ACCESS_NS * 1000) + SYNC_LATENCY;
  localparam int unsigned WRITE_PULSE_CYCLES = ceilCycles(WRITE_PULSE_NS * 1000);
  localparam int unsigned SEQ_PULSE_CYCLES = ceilCycles(SEQ_PULSE_NS * 1000);
  localparam int unsigned RECOVER_CYCLES = ceilCycles(OUTPUT_OFF_NS * 1000);
  // Milliseconds in picoseconds overflow 32 bits; scale whole milliseconds instead
  localparam int unsigned NV_SAVE_CYCLES = NV_SAVE_DURATION_MS * ceilCycles(1000000000);
  localparam int unsigned NV_RELOAD_CYCLES = ceilCycles(NV_RELOAD_DURATION_US * 1000000);
  localparam int unsigned POWERUP_RELOAD_CYCLES =
    ceilCycles(POWERUP_RELOAD_DURATION_US * 1000000);

  localparam logic [12:0] SEQ_ADDR_0 = 13'h0000;
  localparam logic [12:0] SEQ_ADDR_1 = 13'h1555;
  localparam logic [12:0] SEQ_ADDR_2 = 13'h0AAA;
  localparam logic [12:0] SEQ_ADDR_3 = 13'h1FFF;
  localparam logic [12:0] SEQ_ADDR_4 = 13'h10F0;
  localparam logic [12:0] SEQ_ADDR_SAVE = 13'h0F0F;
  localparam logic [12:0] SEQ_ADDR_RELOAD = 13'h0F0E;

  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_WRITE = 2'b01,
    OP_SAVE = 2'b10,
    OP_RELOAD = 2'b11
  } op_type;

  typedef struct packed {
    op_type op;
    logic [12:0] addr;
    logic [7:0] data;
  } cmd_type;

  typedef struct packed {
    logic chipEnN;
    logic outEnN;
    logic writeEnN;
    logic [12:0] byteSelectLines;
  } pins_type;

  localparam pins_type PINS_IDLE = '{chipEnN: 1'b1, outEnN: 1'b1, writeEnN: 1'b1,
                                     byteSelectLines: 13'h0000};

endpackage : nv_host_pkg
`default_nettype wire

// ===== rtl/nv_shadow_sram_control.sv
// Purpose: Host-side controller driving an asynchronous nonvolatile-shadow SRAM.
// Assumes: Supply-good pin from an external monitor at the trigger level.
// Notes: One command at a time; nonvolatile commands issue the six-read sequence.
// Operation
// - Host keeps the address stable across the whole write.
// - Host frames every sequence read with its own chip-enable pulse.
// - Only reads with write enable high count; output enable may stay high.
// - Keep write or chip enable high when power-up recall ends.
`timescale 1ns/1ps
`default_nettype none
module nv_shadow_sram_control #(
  parameter int unsigned NV_SAVE_CYCLES = nv_host_pkg::NV_SAVE_CYCLES,
  parameter int unsigned NV_RELOAD_CYCLES = nv_host_pkg::NV_RELOAD_CYCLES,
  parameter int unsigned POWERUP_RELOAD_CYCLES = nv_host_pkg::POWERUP_RELOAD_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cmdValid,
  input wire nv_host_pkg::cmd_type cmd,
  output logic cmdReady,
  output logic busy,
  output logic rdValid,
  output logic [7:0] rdData,
  output nv_host_pkg::pins_type memPins,
  output logic [7:0] dataBusLinesOut,
  output logic dataBusLinesOutEnN,
  input wire logic [7:0] dataBusLinesIn,
  input wire logic supplyGood
);

  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_IDLE = 3'b001,
    ST_SETUP = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_RECOVER = 3'b100,
    ST_NVWAIT = 3'b101
  } state_type;

  // Address of each step of the nonvolatile sequence
  function automatic logic [12:0] seqAddr(input logic [2:0] step, input logic isSave);
    logic [12:0] a;
    case (step)
      3'h0: a = nv_host_pkg::SEQ_ADDR_0;
      3'h1: a = nv_host_pkg::SEQ_ADDR_1;
      3'h2: a = nv_host_pkg::SEQ_ADDR_2;
      3'h3: a = nv_host_pkg::SEQ_ADDR_3;
      3'h4: a = nv_host_pkg::SEQ_ADDR_4;
      default: a = isSave ? nv_host_pkg::SEQ_ADDR_SAVE : nv_host_pkg::SEQ_ADDR_RELOAD;
    endcase
    return a;
  endfunction : seqAddr

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic [8:0] syncPins;
  logic pwrOk;
  logic [7:0] syncData;

  pin_sync #(
    .WIDTH(9)
  ) u_pin_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pinIn({supplyGood, dataBusLinesIn}),
    .syncOut(syncPins)
  );

  assign pwrOk = syncPins[8];
  assign syncData = syncPins[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  state_type state;
  state_type next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  nv_host_pkg::cmd_type cur;
  nv_host_pkg::cmd_type next_cur;
  logic [2:0] seqStep;
  logic [2:0] next_seqStep;
  nv_host_pkg::pins_type next_memPins;
  logic [7:0] next_dataBusLinesOut;
  logic next_dataBusLinesOutEnN;
  logic [7:0] next_rdData;
  logic next_rdValid;
  logic isNv;

  assign isNv = cur.op[1];
  // Every command, reads and reloads too, is refused while the supply is low
  assign cmdReady = (state == ST_IDLE) && pwrOk;
  assign busy = (state != ST_IDLE);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cur = cur;
    next_seqStep = seqStep;
    next_memPins = memPins;
    next_dataBusLinesOut = dataBusLinesOut;
    next_dataBusLinesOutEnN = dataBusLinesOutEnN;
    next_rdData = rdData;
    next_rdValid = 1'b0;
    if (!pwrOk && (state != ST_BOOT)) begin
      // Brown-out: drop everything, the part reloads on recovery
      next_state = ST_BOOT;
      next_memPins = nv_host_pkg::PINS_IDLE;
      next_dataBusLinesOutEnN = 1'b1;
      next_seqStep = 3'h0;
      next_cnt = POWERUP_RELOAD_CYCLES;
    end else begin
      case (state)
        ST_BOOT: begin
          next_memPins = nv_host_pkg::PINS_IDLE;
          if (!pwrOk) begin
            next_cnt = POWERUP_RELOAD_CYCLES;
          end else if (cnt == 32'h0) begin
            next_state = ST_IDLE;
          end else begin
            next_cnt = cnt - 32'h1;
          end
        end
        ST_IDLE: begin
          if (cmdValid && pwrOk) begin
            next_cur = cmd;
            next_seqStep = 3'h0;
            next_state = ST_SETUP;
            if (cmd.op[1]) begin
              next_memPins.byteSelectLines = seqAddr(3'h0, cmd.op == nv_host_pkg::OP_SAVE);
            end else begin
              next_memPins.byteSelectLines = cmd.addr;
            end
            if (cmd.op == nv_host_pkg::OP_WRITE) begin
              next_dataBusLinesOut = cmd.data;
              next_dataBusLinesOutEnN = 1'b0;
            end
          end
        end
        ST_SETUP: begin
          next_memPins.chipEnN = 1'b0;
          next_state = ST_ACTIVE;
          if (cur.op == nv_host_pkg::OP_WRITE) begin
            next_memPins.writeEnN = 1'b0;
            next_cnt = nv_host_pkg::WRITE_PULSE_CYCLES - 1;
          end else if (cur.op == nv_host_pkg::OP_READ) begin
            next_memPins.outEnN = 1'b0;
            next_cnt = nv_host_pkg::READ_PULSE_CYCLES - 1;
          end else begin
            // Sequence reads leave output enable high, no bus contention
            next_cnt = nv_host_pkg::SEQ_PULSE_CYCLES - 1;
          end
        end
        ST_ACTIVE: begin
          if (cnt != 32'h0) begin
            next_cnt = cnt - 32'h1;
          end else begin
            next_memPins.chipEnN = 1'b1;
            next_memPins.writeEnN = 1'b1;
            next_memPins.outEnN = 1'b1;
            next_cnt = nv_host_pkg::RECOVER_CYCLES - 1;
            next_state = ST_RECOVER;
            if (cur.op == nv_host_pkg::OP_READ) begin
              next_rdData = syncData;
              next_rdValid = 1'b1;
            end
          end
        end
        ST_RECOVER: begin
          // Drive held one cycle past write end for data hold
          next_dataBusLinesOutEnN = 1'b1;
          if (cnt != 32'h0) begin
            next_cnt = cnt - 32'h1;
          end else if (!isNv) begin
            next_state = ST_IDLE;
          end else if (seqStep == 3'(nv_host_pkg::SEQ_LEN - 1)) begin
            next_seqStep = 3'h0;
            next_state = ST_NVWAIT;
            // Save runs every time, dirty or not
            next_cnt = (cur.op == nv_host_pkg::OP_SAVE) ? NV_SAVE_CYCLES : NV_RELOAD_CYCLES;
          end else begin
            // No other access may slip in between steps
            next_seqStep = seqStep + 3'h1;
            next_memPins.byteSelectLines =
              seqAddr(seqStep + 3'h1, cur.op == nv_host_pkg::OP_SAVE);
            next_state = ST_SETUP;
          end
        end
        ST_NVWAIT: begin
          // Part ignores all pins until the operation completes
          if (cnt == 32'h0) begin
            next_state = ST_IDLE;
          end else begin
            next_cnt = cnt - 32'h1;
          end
        end
        default: begin
          next_state = ST_BOOT;
          next_memPins = nv_host_pkg::PINS_IDLE;
          next_cnt = POWERUP_RELOAD_CYCLES;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_BOOT;
      cnt <= POWERUP_RELOAD_CYCLES;
      cur <= '0;
      seqStep <= 3'h0;
      memPins <= nv_host_pkg::PINS_IDLE;
      dataBusLinesOut <= 8'h00;
      dataBusLinesOutEnN <= 1'b1;
      rdData <= 8'h00;
      rdValid <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cur <= next_cur;
      seqStep <= next_seqStep;
      memPins <= next_memPins;
      dataBusLinesOut <= next_dataBusLinesOut;
      dataBusLinesOutEnN <= next_dataBusLinesOutEnN;
      rdData <= next_rdData;
      rdValid <= next_rdValid;
    end
  end

endmodule : nv_shadow_sram_control
`default_nettype wire

// ===== rtl/pin_sync.sv
// Purpose: Three-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to core_clk.
// Notes: Output follows only when second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 9
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_syncOut;

  always_comb begin
    next_syncOut = syncOut;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_syncOut[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      syncOut <= next_syncOut;
    end
  end

endmodule : pin_sync
`default_nettype wire

// ===== verification/nv_host_chk.sv
// Purpose: Pin and handshake checks on the nvSRAM host controller.
// Assumes: One clock domain; sees top ports only.
// Notes: Pulse lengths follow the slowest speed grade.
`timescale 1ns/1ps
`default_nettype none
module nv_host_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cmdValid,
  input wire nv_host_pkg::cmd_type cmd,
  input wire logic cmdReady,
  input wire logic busy,
  input wire logic rdValid,
  input wire logic [7:0] rdData,
  input wire nv_host_pkg::pins_type memPins,
  input wire logic [7:0] dataBusLinesOut,
  input wire logic dataBusLinesOutEnN,
  input wire logic [7:0] dataBusLinesIn,
  input wire logic supplyGood
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  addr_hold_a: assert property (!memPins.chipEnN |-> $stable(memPins.byteSelectLines))
    else $error("address moved while selected");
  write_drive_a: assert property (!memPins.writeEnN |->
    !dataBusLinesOutEnN && memPins.outEnN && $stable(dataBusLinesOut))
    else $error("write without steady driven data");
  read_release_a: assert property (!memPins.outEnN |->
    dataBusLinesOutEnN && memPins.writeEnN) else $error("bus driven during read");
  write_pulse_a: assert property ($fell(memPins.writeEnN) |->
    (!memPins.chipEnN && !memPins.writeEnN) [*8] ##1 (memPins.chipEnN && memPins.writeEnN))
    else $error("write pulse length wrong");
  seq_pulse_a: assert property (disable iff (sys_rst || !supplyGood)
    $fell(memPins.chipEnN) && memPins.writeEnN && memPins.outEnN |->
    !memPins.chipEnN [*8] ##1 memPins.chipEnN [*4]) else $error("sequence pulse wrong");
  read_timing_a: assert property ($fell(memPins.outEnN) |->
    ##15 (rdValid && memPins.outEnN)) else $error("read data late or early");
  valid_pulse_a: assert property (rdValid |=> !rdValid) else $error("read valid too long");
  accept_busy_a: assert property (cmdValid && cmdReady |=> busy && !cmdReady)
    else $error("accepted command did not start");
  supply_block_a: assert property (!supplyGood [*7] |->
    !cmdReady && memPins.chipEnN && memPins.writeEnN) else $error("access while supply low");
endmodule : nv_host_chk
bind nv_shadow_sram_control nv_host_chk nv_host_chk_inst (.core_clk, .sys_rst, .cmdValid, .cmd,
  .cmdReady, .busy, .rdValid, .rdData, .memPins, .dataBusLinesOut, .dataBusLinesOutEnN,
  .dataBusLinesIn, .supplyGood);
`default_nettype wire

// ===== verification/nv_sram_model.sv
// Purpose: Behavioural nonvolatile-shadow SRAM on the host pins.
// Assumes: Store and recall finish at once; host waits the full time anyway.
// Notes: Undriven data bus shows the inverse of the last byte.
`timescale 1ns/1ps
`default_nettype none
module nv_sram_model (
  input wire logic supplyGood,
  input wire nv_host_pkg::pins_type memPins,
  input wire logic [7:0] dataBusLinesOut,
  output logic [7:0] dataBusLinesIn
);
  logic [7:0] cells [8192];
  logic [7:0] shadow [8192];
  logic [7:0] lastOut = 8'h00;
  logic [7:0] wrData;
  logic [12:0] wrAddr;
  logic inWrite = 1'b0;
  logic written = 1'b0;
  logic prevCe = 1'b1;
  int step = 0;
  int saves = 0;
  int reloads = 0;
  localparam logic [12:0] SEQ [5] = '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF, 13'h10F0};
  initial begin
    foreach (cells[i]) cells[i] = 8'h00;
    foreach (shadow[i]) shadow[i] = 8'h00;
  end
  task automatic saveNow();
    foreach (shadow[i]) shadow[i] = 8'hFF;
    foreach (shadow[i]) shadow[i] = cells[i];
    saves++;
    written = 1'b0;
  endtask : saveNow
  task automatic reloadNow();
    foreach (cells[i]) cells[i] = 8'h00;
    foreach (cells[i]) cells[i] = shadow[i];
    reloads++;
    written = 1'b0;
  endtask : reloadNow
  ////////////////////////////////////////////////////////////////////////////
  // One process, so a write ending is never mistaken for a sequence read
  always @(memPins or dataBusLinesOut or supplyGood) begin
    if (!memPins.chipEnN && !memPins.outEnN && memPins.writeEnN && supplyGood) begin
      dataBusLinesIn = cells[memPins.byteSelectLines];
      lastOut = dataBusLinesIn;
    end else begin
      dataBusLinesIn = ~lastOut;
    end
    if (!memPins.chipEnN && !memPins.writeEnN) begin
      inWrite = 1'b1;
      wrAddr = memPins.byteSelectLines;
      wrData = dataBusLinesOut;
    end else if (inWrite) begin
      inWrite = 1'b0;
      step = 0;
      if (supplyGood) begin
        cells[wrAddr] = wrData;
        written = 1'b1;
      end
    end else if (memPins.chipEnN && !prevCe) begin
      if (step == 5 && memPins.byteSelectLines == 13'h0F0F) begin
        if (supplyGood) saveNow();
        step = 0;
      end else if (step == 5 && memPins.byteSelectLines == 13'h0F0E) begin
        reloadNow();
        step = 0;
      end else if (step < 5 && memPins.byteSelectLines == SEQ[step]) begin
        step++;
      end else begin
        step = (memPins.byteSelectLines == 13'h0000) ? 1 : 0;
      end
    end
    prevCe = memPins.chipEnN;
  end
  always @(negedge supplyGood) if (written) saveNow();
  always @(posedge supplyGood) reloadNow();
endmodule : nv_sram_model
`default_nettype wire

// ===== verification/testbench.sv
// Purpose: Self-checking bench for the nvSRAM host controller.
// Assumes: Shortened store and recall counts.
// Notes: Inputs change on the falling edge only.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin comparisons++; if ((a) !== (b)) begin failCount++; \
  $display("unexpected %0t got %h want %h", $time, a, b); end end
module testbench;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmdValid = 1'b0;
  logic supplyGood = 1'b1;
  nv_host_pkg::cmd_type cmd = '0;
  nv_host_pkg::pins_type memPins;
  logic cmdReady, busy, rdValid, dataBusLinesOutEnN;
  logic [7:0] rdData, dataBusLinesOut, dataBusLinesIn, got;
  int failCount = 0;
  int comparisons = 0;
  int cycles = 0;
  nv_shadow_sram_control #(.NV_SAVE_CYCLES(20), .NV_RELOAD_CYCLES(10),
    .POWERUP_RELOAD_CYCLES(10)) nv_shadow_sram_control_inst (.core_clk, .sys_rst, .cmdValid,
    .cmd, .cmdReady, .busy, .rdValid, .rdData, .memPins, .dataBusLinesOut,
    .dataBusLinesOutEnN, .dataBusLinesIn, .supplyGood);
  nv_sram_model nv_sram_model_inst (.supplyGood, .memPins, .dataBusLinesOut, .dataBusLinesIn);
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      failCount++;
      completeRun();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : completeRun
  task automatic issue(input nv_host_pkg::op_type op, input logic [12:0] a, input logic [7:0] d);
    // A missing read strobe leaves an unknown, never a stale byte
    got = 8'hXX;
    @(negedge core_clk);
    cmd = '{op: op, addr: a, data: d};
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    cmdValid = 1'b0;
    while (busy !== 1'b0) begin
      if (rdValid === 1'b1) got = rdData;
      @(negedge core_clk);
    end
  endtask : issue
  task automatic writeRead();
    logic [12:0] addrs [3];
    logic [7:0] vals [3];
    addrs = '{13'h0000, 13'h1234, 13'h1FFF};
    vals = '{8'hA5, 8'h3C, 8'hF0};
    foreach (addrs[i]) issue(nv_host_pkg::OP_WRITE, addrs[i], vals[i]);
    foreach (addrs[i]) begin
      issue(nv_host_pkg::OP_READ, addrs[i], 8'h00);
      `CHECK(got, vals[i])
    end
  endtask : writeRead
  task automatic softSave();
    int s;
    s = nv_sram_model_inst.saves;
    issue(nv_host_pkg::OP_WRITE, 13'h1234, 8'h77);
    issue(nv_host_pkg::OP_SAVE, 13'h0000, 8'h00);
    `CHECK(nv_sram_model_inst.shadow[13'h1234], 8'h77)
    issue(nv_host_pkg::OP_SAVE, 13'h0000, 8'h00);
    `CHECK(nv_sram_model_inst.saves, s + 2)
  endtask : softSave
  task automatic softReload();
    int r;
    r = nv_sram_model_inst.reloads;
    issue(nv_host_pkg::OP_WRITE, 13'h1234, 8'h11);
    issue(nv_host_pkg::OP_RELOAD, 13'h0000, 8'h00);
    issue(nv_host_pkg::OP_READ, 13'h1234, 8'h00);
    `CHECK(got, 8'h77)
    issue(nv_host_pkg::OP_RELOAD, 13'h0000, 8'h00);
    `CHECK(nv_sram_model_inst.reloads, r + 2)
    `CHECK(nv_sram_model_inst.shadow[13'h1234], 8'h77)
  endtask : softReload
  task automatic supplyDrop();
    int s;
    issue(nv_host_pkg::OP_WRITE, 13'h0AAA, 8'h22);
    s = nv_sram_model_inst.saves;
    @(negedge core_clk);
    cmd = '{op: nv_host_pkg::OP_SAVE, addr: 13'h0000, data: 8'h00};
    cmdValid = 1'b1;
    @(negedge core_clk);
    cmdValid = 1'b0;
    // Cut the supply part way through the six-read sequence
    repeat (20) @(negedge core_clk);
    supplyGood = 1'b0;
    repeat (10) @(negedge core_clk);
    `CHECK(cmdReady, 1'b0)
    `CHECK(nv_sram_model_inst.saves, s + 1)
    supplyGood = 1'b1;
    repeat (10) @(negedge core_clk);
    `CHECK(cmdReady, 1'b0)
    supplyGood = 1'b0;
    repeat (10) @(negedge core_clk);
    `CHECK(nv_sram_model_inst.saves, s + 1)
    supplyGood = 1'b1;
    issue(nv_host_pkg::OP_READ, 13'h0AAA, 8'h00);
    `CHECK(got, 8'h22)
  endtask : supplyDrop
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge core_clk);
    `CHECK(cmdReady, 1'b0)
    sys_rst = 1'b0;
    writeRead();
    softSave();
    softReload();
    supplyDrop();
    completeRun();
  end
endmodule : testbench
`default_nettype wire
